// ### hw/mdfs_chop_if.sv
// Bundle between the fault status top and the bridge chopper.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface mdfs_chop_if;
  import mdfs_pkg::*;
  logic enable;
  logic quiet;
  logic [DUTY_W-1:0] duty;
  logic [OFF_TIME_W-1:0] offTime;
  logic currentTrip;
  logic drive;
  modport ctrl (output enable, output quiet, output duty, output offTime, output currentTrip, input drive);
  modport chop (input enable, input quiet, input duty, input offTime, input currentTrip, output drive);
endinterface : mdfs_chop_if

// ### hw/mdfs_chopper.sv
// Bridge chopper: voltage-mode PWM in quiet mode, peak-current
// chopper with fixed off time otherwise.
// Assumes currentTrip is already synchronised to clk.
`timescale 1ns/100ps
module mdfs_chopper (
  input wire logic clk,
  input wire logic resetn,
  mdfs_chop_if.chop ch
);
  import mdfs_pkg::*;

  mdfs_chop_state_type state, next_state;
  logic [OFF_CNT_W-1:0] offCnt, next_offCnt;
  logic [DUTY_W-1:0] pwmCnt, next_pwmCnt;
  logic next_drive;
  logic [OFF_CNT_W-1:0] offLimit;

  assign offLimit = OFF_CNT_W'(ch.offTime * OFF_UNIT_CYC);

  always_comb begin
    next_state = state;
    next_offCnt = offCnt;
    next_pwmCnt = pwmCnt + 8'h01;
    next_drive = 1'b0;
    if (!ch.enable) begin
      next_state = CHOP_DRIVE;
      next_offCnt = '0;
    end else if (ch.quiet) begin
      // No current sensing: duty alone sets the coil voltage
      next_drive = (pwmCnt < ch.duty); // RULE_11
      next_state = CHOP_DRIVE;
    end else begin
      case (state)
        CHOP_DRIVE: begin
          next_drive = !ch.currentTrip;
          if (ch.currentTrip) begin
            next_state = CHOP_OFF;
            next_offCnt = '0;
          end
        end
        CHOP_OFF: begin
          if (offCnt >= offLimit - 9'h001) begin
            next_state = CHOP_DRIVE;
          end else begin
            next_offCnt = offCnt + 9'h001;
          end
        end
        default: next_state = CHOP_DRIVE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= CHOP_DRIVE;
      offCnt <= '0;
      pwmCnt <= '0;
      ch.drive <= 1'b0;
    end else begin
      state <= next_state;
      offCnt <= next_offCnt;
      pwmCnt <= next_pwmCnt;
      ch.drive <= next_drive;
    end
  end

  a_voltage_pwm: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
    (ch.enable && ch.quiet) |=> (ch.drive == ($past(pwmCnt) < $past(ch.duty))))
    else $error("quiet mode drive does not follow pwm duty");

endmodule : mdfs_chopper

// ### hw/mdfs_fault_status.sv
// Driver fault status top: thermal, open-load and short flags,
// bridge disable, chopper mode report and the bridge chopper.
// Assumes analog comparator outputs and pins arrive asynchronously;
// off time and duty come from clk-domain configuration registers.
//
// Notes on behaviour
// RULE_01 - Four temperature comparator levels read at bits 11 to 8.
// RULE_02 - Open-load per phase at bits 7 and 6; no driver action taken.
// RULE_03 - Controller should read open-load flags only during slow motion.
// RULE_04 - Low-side short sets bit 5 or 4 and disables the bridge.
// RULE_05 - Ground short sets bit 3 or 2 and disables the bridge.
// RULE_06 - Short flags hold until off time is zero or enable pin deasserted.
// RULE_07 - Each chopper mode keeps its own set of short flags.
// RULE_08 - Shutdown temperature reached sets bit 1, common to both bridges.
// RULE_09 - After shutdown, bridge stays off until pre-warning also clears.
// RULE_10 - Pre-warning threshold exceeded shows at bit 0, common to bridges.
// RULE_11 - Quiet mode sets coil current by voltage-mode PWM duty.
// RULE_12 - Bit 30 reports quiet mode as 1, current chopper as 0.
// RULE_13 - Status word is read-only; reading has no side effect.
`timescale 1ns/100ps
module mdfs_fault_status (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [mdfs_pkg::TEMP_W-1:0] tempCmpIn,
  input wire logic prewarnIn,
  input wire logic shutdownIn,
  input wire logic [1:0] openLoadIn,
  input wire logic [1:0] lowsideShortIn,
  input wire logic [1:0] groundShortIn,
  input wire logic enableLowInputN,
  input wire logic quietModeIn,
  input wire logic currentTripIn,
  input wire logic [mdfs_pkg::OFF_TIME_W-1:0] offTimeSetting,
  input wire logic [mdfs_pkg::DUTY_W-1:0] pwmDuty,
  output logic [mdfs_pkg::STATUS_W-1:0] driverFaultStatus,
  output logic bridgeEnable,
  output logic bridgeDrive
);
  import mdfs_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] rawIn;
  logic [SYNC_W-1:0] syncd;

  // Enable pin enters inverted so the flops' reset value means disabled
  assign rawIn = {currentTripIn, quietModeIn, ~enableLowInputN, groundShortIn,
                  lowsideShortIn, openLoadIn, shutdownIn, prewarnIn, tempCmpIn};

  mdfs_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .asyncIn(rawIn),
    .syncOut(syncd)
  );

  logic [TEMP_W-1:0] tempSync;
  logic prewarnSync;
  logic shutdownSync;
  logic [1:0] openLoadSync;
  logic [SHORT_W-1:0] shortDet;
  logic enableLowSync;
  logic quietSync;
  logic tripSync;

  assign tempSync = syncd[IDX_TEMP +: TEMP_W];
  assign prewarnSync = syncd[IDX_OTPW];
  assign shutdownSync = syncd[IDX_SHUTDOWN];
  assign openLoadSync = syncd[IDX_OPEN +: 2];
  // Order matches status bits 5..2: low B, low A, ground B, ground A
  assign shortDet = {syncd[IDX_LOWS +: 2], syncd[IDX_GNDS +: 2]};
  assign enableLowSync = ~syncd[IDX_ENABLE_LOW];
  assign quietSync = syncd[IDX_QUIET];
  assign tripSync = syncd[IDX_TRIP];

  // ----------------------------------------------------------------
  // Fault state
  // ----------------------------------------------------------------
  logic [SHORT_W-1:0] shortQuiet, next_shortQuiet;
  logic [SHORT_W-1:0] shortCycle, next_shortCycle;
  logic thermalShutdownFlag, next_thermalShutdownFlag;
  logic next_bridgeEnable;
  logic clearShorts;

  // Either form of software or pin disable releases the latches
  assign clearShorts = enableLowSync || (offTimeSetting == 4'h0);

  always_comb begin
    next_shortQuiet = clearShorts ? 4'h0 : shortQuiet; // RULE_06
    next_shortCycle = clearShorts ? 4'h0 : shortCycle; // RULE_06
    // Detection wins over a clear in the same cycle
    if (quietSync) begin
      next_shortQuiet = next_shortQuiet | shortDet; // RULE_07
    end else begin
      next_shortCycle = next_shortCycle | shortDet; // RULE_07
    end
    // Falling below shutdown is not enough; pre-warning must clear too
    next_thermalShutdownFlag = shutdownSync || (thermalShutdownFlag && prewarnSync); // RULE_09
    // Any latched short, either mode, keeps the bridge off
    next_bridgeEnable = !enableLowSync && (offTimeSetting != 4'h0)
                        && (next_shortQuiet == 4'h0) && (next_shortCycle == 4'h0) // RULE_04 RULE_05
                        && !next_thermalShutdownFlag; // RULE_09
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shortQuiet <= 4'h0;
      shortCycle <= 4'h0;
      thermalShutdownFlag <= 1'b0;
      bridgeEnable <= 1'b0;
    end else begin
      shortQuiet <= next_shortQuiet;
      shortCycle <= next_shortCycle;
      thermalShutdownFlag <= next_thermalShutdownFlag;
      bridgeEnable <= next_bridgeEnable;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // There is no write path at all, and reading is a plain wire tap,
  // so no flag can be disturbed by host traffic.
  logic [STATUS_W-1:0] next_status;

  always_comb begin
    next_status = STATUS_RESET; // RULE_13
    next_status[BIT_MODE] = quietSync; // RULE_12
    next_status[BIT_TEMP_LSB +: TEMP_W] = tempSync; // RULE_01
    next_status[BIT_OPEN_LSB +: 2] = openLoadSync; // RULE_02
    next_status[BIT_SHORT_LSB +: SHORT_W] = quietSync ? next_shortQuiet : next_shortCycle; // RULE_07
    next_status[BIT_SHUTDOWN] = next_thermalShutdownFlag; // RULE_08
    next_status[BIT_OTPW] = prewarnSync; // RULE_10
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      driverFaultStatus <= STATUS_RESET;
    end else begin
      driverFaultStatus <= next_status;
    end
  end

  // ----------------------------------------------------------------
  // Bridge chopper
  // ----------------------------------------------------------------
  mdfs_chop_if chopIf ();

  assign chopIf.enable = bridgeEnable;
  assign chopIf.quiet = quietSync;
  assign chopIf.duty = pwmDuty;
  assign chopIf.offTime = offTimeSetting;
  assign chopIf.currentTrip = tripSync;
  assign bridgeDrive = chopIf.drive;

  mdfs_chopper u_chopper (
    .clk(clk),
    .resetn(resetn),
    .ch(chopIf.chop)
  );

  // ----------------------------------------------------------------
  // Assertion helpers
  // ----------------------------------------------------------------
  // Input pipeline is three edges deep; checks start once it is full
  logic [1:0] settleCnt, next_settleCnt;
  logic settled;

  assign settled = (settleCnt == SETTLE_CYC);

  always_comb begin
    next_settleCnt = settled ? settleCnt : settleCnt + 2'h1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settleCnt <= 2'h0;
    end else begin
      settleCnt <= next_settleCnt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_temp_cmp_map: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
    settled |-> (driverFaultStatus[11:8] == $past(tempCmpIn, 3)))
    else $error("temperature comparator bits do not track inputs");

  a_open_load_map: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
    settled |-> (driverFaultStatus[7:6] == $past(openLoadIn, 3)))
    else $error("open load bits do not track inputs");

  a_open_load_harmless: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
    (settled && (driverFaultStatus[7:6] != 2'h0) && (shortQuiet == 4'h0) && (shortCycle == 4'h0)
     && !driverFaultStatus[1] && !$past(enableLowInputN, 3) && (offTimeSetting != 4'h0)
     && ($past(offTimeSetting) != 4'h0)) |-> bridgeEnable)
    else $error("open load alone disabled the bridge");

  a_lowside_disable: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
    (driverFaultStatus[5:4] != 2'h0) |-> !bridgeEnable)
    else $error("bridge enabled with low side short flagged");

  a_ground_disable: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
    (driverFaultStatus[3:2] != 2'h0) |-> !bridgeEnable)
    else $error("bridge enabled with ground short flagged");

  a_short_hold: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
    !clearShorts |=> (((shortQuiet & $past(shortQuiet)) == $past(shortQuiet))
                      && ((shortCycle & $past(shortCycle)) == $past(shortCycle))))
    else $error("short flag dropped without driver disable");

  a_short_release: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
    (clearShorts && (shortDet == 4'h0)) |=> ((shortQuiet == 4'h0) && (shortCycle == 4'h0)))
    else $error("short flags not released by driver disable");

  a_quiet_set_apart: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
    (!quietSync && !clearShorts) |=> $stable(shortQuiet))
    else $error("quiet mode short set changed in current chopper mode");

  a_cycle_set_apart: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
    (quietSync && !clearShorts) |=> $stable(shortCycle))
    else $error("current chopper short set changed in quiet mode");

  a_shutdown_flag: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
    shutdownSync |=> (driverFaultStatus[1] && !bridgeEnable))
    else $error("shutdown temperature did not set flag and disable");

  a_shutdown_hold: assert property (@(posedge clk) disable iff (!resetn) // RULE_09
    (thermalShutdownFlag && prewarnSync) |=> (thermalShutdownFlag && driverFaultStatus[1] && !bridgeEnable))
    else $error("shutdown released before pre-warning cleared");

  a_prewarn_map: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
    settled |-> (driverFaultStatus[0] == $past(prewarnIn, 3)))
    else $error("pre-warning bit does not track input");

  a_mode_report: assert property (@(posedge clk) disable iff (!resetn) // RULE_12
    settled |-> (driverFaultStatus[30] == $past(quietModeIn, 3)))
    else $error("chopper mode bit does not track mode");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn) // RULE_13
    (driverFaultStatus[31] == 1'b0) && (driverFaultStatus[29:12] == 18'h0))
    else $error("unimplemented status bits not zero");

  // ----------------------------------------------------------------
  // Bridge control and status timing
  // ----------------------------------------------------------------
  // Status fields trail their synchronised levels by one edge
  a_temp_cmp_live: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
    driverFaultStatus[11:8] == $past(tempSync))
    else $error("temperature bits do not follow synchronised comparators");

  a_open_load_live: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
    driverFaultStatus[7:6] == $past(openLoadSync))
    else $error("open load bits latched or lost");

  a_prewarn_live: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
    driverFaultStatus[0] == $past(prewarnSync))
    else $error("pre-warning bit does not follow comparator");

  a_mode_bit_live: assert property (@(posedge clk) disable iff (!resetn) // RULE_12
    driverFaultStatus[30] == $past(quietSync))
    else $error("mode bit does not follow active chopper");

  a_short_shown: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
    driverFaultStatus[5:2] == ($past(quietSync) ? shortQuiet : shortCycle))
    else $error("short bits do not show the active mode set");

  a_short_latch: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
    (shortDet != 4'h0) |=> (((shortQuiet | shortCycle) & $past(shortDet)) == $past(shortDet)))
    else $error("detected short not latched");

  a_bridge_clean: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
    bridgeEnable |-> ((shortQuiet == 4'h0) && (shortCycle == 4'h0) && !thermalShutdownFlag))
    else $error("bridge enabled with a latched fault");

  a_drive_gated: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
    !bridgeEnable |=> !bridgeDrive)
    else $error("bridge driven while disabled");

  a_pin_disable: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
    enableLowSync |=> !bridgeEnable)
    else $error("bridge enabled while enable pin deasserted");

  a_offtime_disable: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
    (offTimeSetting == 4'h0) |=> !bridgeEnable)
    else $error("bridge enabled with zero off time");

  a_enable_recover: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
    (!enableLowSync && (offTimeSetting != 4'h0) && (shortQuiet == 4'h0) && (shortCycle == 4'h0)
     && (shortDet == 4'h0) && !shutdownSync && !thermalShutdownFlag) |=> bridgeEnable)
    else $error("bridge stayed off with no fault");

  a_thermal_release: assert property (@(posedge clk) disable iff (!resetn) // RULE_09
    (!shutdownSync && !prewarnSync) |=> (!thermalShutdownFlag && !driverFaultStatus[1]))
    else $error("shutdown flag held after cooling");

  a_shutdown_common: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
    driverFaultStatus[1] == thermalShutdownFlag)
    else $error("shutdown bit differs from common latch");

endmodule : mdfs_fault_status

// ### hw/mdfs_pkg.sv
// Constants and types shared by the driver fault status logic.
// Assumes a single 100 MHz clock and asynchronous active-low reset.
package mdfs_pkg;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int STATUS_W = 32;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam int BIT_MODE = 30;
  localparam int BIT_TEMP_LSB = 8;
  localparam int BIT_OPEN_LSB = 6;
  localparam int BIT_SHORT_LSB = 2;
  localparam int BIT_SHUTDOWN = 1;
  localparam int BIT_OTPW = 0;
  localparam int TEMP_W = 4;
  localparam int SHORT_W = 4;

  // ----------------------------------------------------------------
  // Synchroniser bundle layout
  // ----------------------------------------------------------------
  localparam int IDX_TEMP = 0;
  localparam int IDX_OTPW = 4;
  localparam int IDX_SHUTDOWN = 5;
  localparam int IDX_OPEN = 6;
  localparam int IDX_LOWS = 8;
  localparam int IDX_GNDS = 10;
  localparam int IDX_ENABLE_LOW = 12;
  localparam int IDX_QUIET = 13;
  localparam int IDX_TRIP = 14;
  localparam int SYNC_W = 15;

  // ----------------------------------------------------------------
  // Chopper timing
  // ----------------------------------------------------------------
  localparam int OFF_TIME_W = 4;
  localparam int DUTY_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OFF_UNIT_NS = 320;
  localparam int OFF_UNIT_CYC = (OFF_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_CNT_W = 9;
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  typedef enum {CHOP_DRIVE, CHOP_OFF} mdfs_chop_state_type;

endpackage : mdfs_pkg

// ### hw/mdfs_sync.sv
// Two-flop synchroniser, one stage pair per bit.
// Assumes inputs are asynchronous levels; outputs are clk-domain levels.
`timescale 1ns/100ps
module mdfs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          stage1[i] <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          stage1[i] <= asyncIn[i];
          syncOut[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule : mdfs_sync

// ### verif/mdfs_coil_model.sv
// Behavioural single motor coil seen through the bridge.
// Assumes bridgeDrive is a clk-domain level from the chopper.
`timescale 1ns/100ps
module mdfs_coil_model #(
  parameter int PEAK = 24
) (
  input wire logic clk,
  input wire logic bridgeDrive,
  output logic currentTrip
);
  int cur = 0;
  // Inductive ramp: rises while driven, decays slower when off
  always @(posedge clk) begin
    if (bridgeDrive && cur < PEAK + 4) begin
      cur <= cur + 2;
    end else if (!bridgeDrive && cur > 0) begin
      cur <= cur - 1;
    end
  end
  assign currentTrip = (cur >= PEAK);
endmodule : mdfs_coil_model

// ### verif/tb_motor_driver_fault_status.sv
// Self-checking bench for the driver fault status top.
// Assumes the coil model closes the current trip loop.
`timescale 1ns/100ps
module tb_motor_driver_fault_status;
  import mdfs_pkg::*;
  typedef struct packed {logic [31:0] st; logic en;} mdfs_note_type;
  logic clk, resetn, prewarnIn, shutdownIn, enableLowInputN, quietModeIn, currentTripIn;
  logic [3:0] tempCmpIn;
  logic [1:0] openLoadIn, lowsideShortIn, groundShortIn;
  logic [OFF_TIME_W-1:0] offTimeSetting;
  logic [DUTY_W-1:0] pwmDuty;
  logic [STATUS_W-1:0] driverFaultStatus;
  logic bridgeEnable, bridgeDrive;
  mdfs_note_type notes[$];
  event look;
  int error_cnt = 0;
  int n_compared = 0;
  int hi;

  mdfs_fault_status u_mdfs_fault_status (.clk(clk), .resetn(resetn), .tempCmpIn(tempCmpIn),
    .prewarnIn(prewarnIn), .shutdownIn(shutdownIn), .openLoadIn(openLoadIn),
    .lowsideShortIn(lowsideShortIn), .groundShortIn(groundShortIn),
    .enableLowInputN(enableLowInputN), .quietModeIn(quietModeIn), .currentTripIn(currentTripIn),
    .offTimeSetting(offTimeSetting), .pwmDuty(pwmDuty), .driverFaultStatus(driverFaultStatus),
    .bridgeEnable(bridgeEnable), .bridgeDrive(bridgeDrive));
  mdfs_coil_model u_mdfs_coil_model (.clk(clk), .bridgeDrive(bridgeDrive), .currentTrip(currentTripIn));

  always #5 clk = ~clk;

  // ------------------------------------------------------------
  // Checking and scoreboard
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  always @(look) begin
    mdfs_note_type n;
    n = notes.pop_front();
    check("status", driverFaultStatus, n.st);
    check("bridge enable", {31'h0, bridgeEnable}, {31'h0, n.en});
  end

  task automatic note(input logic [31:0] st, input logic en);
    notes.push_back('{st, en});
    -> look;
  endtask : note

  // Sync path plus status register: four edges covers it
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  function automatic logic [31:0] stat(input logic q, input logic [3:0] t, input logic [1:0] o,
    input logic [3:0] s, input logic sd, input logic pw);
    stat = {1'h0, q, 18'h0, t, o, s, sd, pw};
  endfunction : stat

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'h0;
    resetn = 1'h0;
    {tempCmpIn, openLoadIn, prewarnIn, quietModeIn, shutdownIn} = 9'h0;
    {lowsideShortIn, groundShortIn} = 4'h0;
    enableLowInputN = 1'h0;
    offTimeSetting = 4'h3;
    pwmDuty = 8'h0;
    void'($urandom(32'h9550));
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'h1;
    note(32'h0, 1'h0);
    step(4);
    note(32'h0, 1'h1);
    // Open-load checked in either chopper mode, with random temperature and pre-warning levels
    for (int i = 0; i < 8; i++) begin
      {tempCmpIn, openLoadIn, prewarnIn, quietModeIn} = 8'($urandom);
      step(4);
      note(stat(quietModeIn, tempCmpIn, openLoadIn, 4'h0, 1'h0, prewarnIn), 1'h1);
    end
    {tempCmpIn, openLoadIn, prewarnIn, quietModeIn} = 8'h0;
    step(4);
    // Each short latches, then clears by off time zero or enable pin
    for (int k = 0; k < 4; k++) begin
      {lowsideShortIn, groundShortIn} = 4'(1 << k);
      step(4);
      note(stat(1'h0, 4'h0, 2'h0, 4'(1 << k), 1'h0, 1'h0), 1'h0);
      {lowsideShortIn, groundShortIn} = 4'h0;
      step(4);
      note(stat(1'h0, 4'h0, 2'h0, 4'(1 << k), 1'h0, 1'h0), 1'h0);
      if (k % 2 == 1) begin
        offTimeSetting = 4'h0;
      end else begin
        enableLowInputN = 1'h1;
      end
      step(4);
      note(32'h0, 1'h0);
      offTimeSetting = 4'h3;
      enableLowInputN = 1'h0;
      step(4);
      note(32'h0, 1'h1);
    end
    // Short caught in current mode stays out of the quiet set
    groundShortIn = 2'h1;
    step(4);
    groundShortIn = 2'h0;
    quietModeIn = 1'h1;
    step(4);
    note(stat(1'h1, 4'h0, 2'h0, 4'h0, 1'h0, 1'h0), 1'h0);
    quietModeIn = 1'h0;
    step(4);
    note(stat(1'h0, 4'h0, 2'h0, 4'h1, 1'h0, 1'h0), 1'h0);
    offTimeSetting = 4'h0;
    step(2);
    offTimeSetting = 4'h3;
    step(4);
    note(32'h0, 1'h1);
    // Thermal shutdown holds until pre-warning clears too
    shutdownIn = 1'h1;
    prewarnIn = 1'h1;
    step(4);
    note(stat(1'h0, 4'h0, 2'h0, 4'h0, 1'h1, 1'h1), 1'h0);
    shutdownIn = 1'h0;
    step(6);
    note(stat(1'h0, 4'h0, 2'h0, 4'h0, 1'h1, 1'h1), 1'h0);
    prewarnIn = 1'h0;
    step(4);
    note(32'h0, 1'h1);
    // Quiet mode: drive high for exactly duty cycles per 256
    quietModeIn = 1'h1;
    pwmDuty = 8'($urandom);
    step(8);
    hi = 0;
    repeat (256) begin
      if (bridgeDrive === 1'h1) begin
        hi++;
      end
      step(1);
    end
    check("pwm duty", 32'(hi), {24'h0, pwmDuty});
    step(2);
    close_out();
  end
endmodule : tb_motor_driver_fault_status
